// >>> hdl/hw_mutex_core.sv
// Hardware mutex: lock word with owner guard and sticky boot flag
`timescale 1ns/100ps
module hw_mutex_core #(
   parameter int INIT_VALUE = 0,
   parameter int INIT_OWNER = 0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input hw_mutex_pkg::bus_req_t busReq,
   output logic [hw_mutex_pkg::DATA_W-1:0] rdData,
   output logic lockHeld
);

   // ---------------------------------------------------------------
   // Bus timing
   // ---------------------------------------------------------------
   // A request is taken at the rising edge where sel and rd or wr are
   // high; there are no wait states and no acknowledge. Read data shows
   // from the edge that takes the read and stands until the next read.
   // A write lands at its taking edge, so a read one edge later sees it.
   // Read and write in one cycle return the word as it was before the write.

   // ---------------------------------------------------------------
   // Build-time checks
   // ---------------------------------------------------------------
   // Both fields are 16 bits wide; larger values cannot be stored
   if (INIT_VALUE < 0 || INIT_VALUE > 2**hw_mutex_pkg::FIELD_W - 1) begin : g_bad_value
      $error("INIT_VALUE does not fit the value field");
   end
   if (INIT_OWNER < 0 || INIT_OWNER > 2**hw_mutex_pkg::FIELD_W - 1) begin : g_bad_owner
      $error("INIT_OWNER does not fit the owner field");
   end

   localparam logic [hw_mutex_pkg::FIELD_W-1:0] INIT_VALUE_F = INIT_VALUE[hw_mutex_pkg::FIELD_W-1:0];
   localparam logic [hw_mutex_pkg::FIELD_W-1:0] INIT_OWNER_F = INIT_OWNER[hw_mutex_pkg::FIELD_W-1:0];

   // ---------------------------------------------------------------
   // State and decode
   // ---------------------------------------------------------------
   hw_mutex_pkg::lock_word_t lockReg;
   hw_mutex_pkg::lock_word_t wrWord;
   logic bootFlagReg;
   logic writeAllow;
   logic lockFree;
   logic wrLock;
   logic wrBoot;
   logic rdStrobe;

   // Written data viewed as owner/value halves
   assign wrWord = hw_mutex_pkg::lock_word_t'(busReq.wdata);

   // Address decode; both word indices are mapped.
   // With sel low, rd and wr count for nothing.
   assign wrLock = busReq.sel && busReq.wr && (busReq.addr == hw_mutex_pkg::LOCK_WORD_IDX);
   assign wrBoot = busReq.sel && busReq.wr && (busReq.addr == hw_mutex_pkg::BOOT_FLAG_IDX);
   assign rdStrobe = busReq.sel && busReq.rd;

   // Owner guard kept in its own small module
   mutex_write_gate u_gate (
      .stored(lockReg),
      .written(wrWord),
      .allow(writeAllow),
      .isFree(lockFree)
   );

   // ---------------------------------------------------------------
   // Lock word
   // ---------------------------------------------------------------
   // Single-cycle compare and update makes the test-and-set atomic:
   // the bus serialises masters, so no two writes see the same state
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lockReg.value <= INIT_VALUE_F;
         lockReg.owner <= INIT_OWNER_F;
      end else if (wrLock && writeAllow) begin
         lockReg <= wrWord;
      end
   end

   // ---------------------------------------------------------------
   // Boot flag
   // ---------------------------------------------------------------
   // Only reset sets it, so no set/clear collision can arise.
   // Bits 31..1 of a boot write are ignored.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bootFlagReg <= hw_mutex_pkg::BOOT_FLAG_RESET;
      end else if (wrBoot && busReq.wdata[hw_mutex_pkg::BOOT_FLAG_BIT]) begin
         bootFlagReg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Registered so the answer comes from a flip-flop; held between reads.
   // Reads touch no state, so polling by waiting masters is harmless.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdData <= hw_mutex_pkg::READ_ZERO;
      end else if (rdStrobe) begin
         if (busReq.addr == hw_mutex_pkg::LOCK_WORD_IDX) begin
            rdData <= lockReg;
         end else begin
            rdData <= hw_mutex_pkg::READ_ZERO;
            rdData[hw_mutex_pkg::BOOT_FLAG_BIT] <= bootFlagReg;
         end
      end
   end

   // Held status for local observers
   assign lockHeld = !lockFree;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Every check is off while reset is low; the reset check looks one edge
   // back, so it lands on the first edge after any release, mid-run too

   // Write to a free lock always lands
   a_write_free: assert property (
      wrLock && (lockReg.value == hw_mutex_pkg::VALUE_FREE) |=> lockReg == $past(wrWord))
      else $error("write to free lock was dropped");

   // Owner may rewrite or release a held lock
   a_write_owner: assert property (
      wrLock && (wrWord.owner == lockReg.owner) |=> lockReg == $past(wrWord))
      else $error("owner write to held lock was dropped");

   // Foreign write to a held lock is ignored
   a_write_blocked: assert property (
      wrLock && (lockReg.value != hw_mutex_pkg::VALUE_FREE) && (wrWord.owner != lockReg.owner)
      |=> $stable(lockReg))
      else $error("foreign write changed a held lock");

   // Only a lock word write may change the lock word
   a_word_quiet: assert property (
      !wrLock
      |=> $stable(lockReg))
      else $error("lock word changed without a write");

   // A held lock keeps its owner until it is released
   a_owner_kept: assert property (
      lockReg.value != hw_mutex_pkg::VALUE_FREE
      |=> lockReg.owner == $past(lockReg.owner))
      else $error("owner of a held lock changed");

   // Read returns the word as it stood at the request
   a_read_word: assert property (
      rdStrobe && (busReq.addr == hw_mutex_pkg::LOCK_WORD_IDX) |=> rdData == $past(lockReg))
      else $error("lock word read returned wrong data");

   // A read with no write leaves all state unchanged
   a_read_quiet: assert property (
      rdStrobe && !busReq.wr |=> $stable(lockReg) && $stable(bootFlagReg))
      else $error("read disturbed mutex state");

   // Read data stands until the next read, so slow masters still see it
   a_read_stands: assert property (
      !rdStrobe
      |=> $stable(rdData))
      else $error("read data moved without a read");

   // Reset leaves the configured word and a set flag
   a_reset_load: assert property (
      $past(!rst_n) |-> lockReg.value == INIT_VALUE_F && lockReg.owner == INIT_OWNER_F
      && bootFlagReg)
      else $error("reset values not loaded");

   // Writing one clears the flag, writing zero keeps it
   a_flag_clear: assert property (
      wrBoot && busReq.wdata[hw_mutex_pkg::BOOT_FLAG_BIT] |=> !bootFlagReg)
      else $error("boot flag not cleared by write of one");

   a_flag_hold: assert property (
      !(wrBoot && busReq.wdata[hw_mutex_pkg::BOOT_FLAG_BIT]) |=> bootFlagReg == $past(bootFlagReg))
      else $error("boot flag changed without a clearing write");

   // Once cleared, only reset can set the flag again
   a_flag_sticky: assert property (
      !bootFlagReg
      |=> !bootFlagReg)
      else $error("boot flag set without a reset");

   // Boot register reads only bit 0, upper bits zero
   a_flag_read: assert property (
      rdStrobe && (busReq.addr == hw_mutex_pkg::BOOT_FLAG_IDX)
      |=> rdData[hw_mutex_pkg::DATA_W-1:1] == '0 && rdData[0] == $past(bootFlagReg))
      else $error("boot register read wrong");

   // Boot register writes never reach the lock word
   a_boot_quiet: assert property (
      wrBoot
      |=> $stable(lockReg))
      else $error("boot register write changed the lock word");

   // Held output follows the value field
   a_held_level: assert property (
      wrLock && writeAllow ##1 1'b1 |-> lockHeld == ($past(wrWord.value) != hw_mutex_pkg::VALUE_FREE))
      else $error("held status disagrees with value field");

   // Held output tracks the stored value field every cycle
   a_held_value: assert property (
      lockHeld == (lockReg.value != hw_mutex_pkg::VALUE_FREE))
      else $error("held status disagrees with stored value");

   // A landed write of value zero frees the lock
   a_release_free: assert property (
      wrLock && writeAllow && (wrWord.value == hw_mutex_pkg::VALUE_FREE)
      |=> !lockHeld)
      else $error("release left the lock held");

   // Main scenarios
   c_acquire: cover property (!lockHeld ##1 wrLock && writeAllow && wrWord.value != '0 ##1 lockHeld);
   c_release: cover property (lockHeld ##1 wrLock && writeAllow && wrWord.value == '0 ##1 !lockHeld);
   c_refused: cover property (wrLock && !writeAllow);
   c_flag_cleared: cover property (bootFlagReg ##1 !bootFlagReg);
   c_owner_rewrite: cover property (lockHeld && wrLock && writeAllow && wrWord.value != '0);

endmodule : hw_mutex_core

// >>> hdl/hw_mutex_pkg.sv
// Constants and carrier types shared by the hardware mutex block
//
// Behaviour
// - Two 32-bit registers; owner high, value low
// - Lock free when value field is zero
// - Lock word readable anytime without side effects
// - Write lands only if free or same owner
// - Boot flag set by reset, write one clears
// - Reset loads value field from build parameter
// - Reset loads owner; with a non-zero value field that owner releases first
package hw_mutex_pkg;

   // ---------------------------------------------------------------
   // Register map (word indices on the slave port)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 1;
   localparam logic [ADDR_W-1:0] LOCK_WORD_IDX = 1'h0;
   localparam logic [ADDR_W-1:0] BOOT_FLAG_IDX = 1'h1;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int FIELD_W = 16;
   localparam int OWNER_LSB = 16;
   localparam int VALUE_LSB = 0;
   localparam int BOOT_FLAG_BIT = 0;
   localparam logic [FIELD_W-1:0] VALUE_FREE = 16'h0000;
   localparam logic BOOT_FLAG_RESET = 1'h1;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [FIELD_W-1:0] owner;
      logic [FIELD_W-1:0] value;
   } lock_word_t;

   typedef struct packed {
      logic sel;
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

endpackage : hw_mutex_pkg

// >>> hdl/mutex_write_gate.sv
// Permission check deciding whether a lock word write may land
`timescale 1ns/100ps
module mutex_write_gate (
   input hw_mutex_pkg::lock_word_t stored,
   input hw_mutex_pkg::lock_word_t written,
   output logic allow,
   output logic isFree
);

   // Free when the value field is all zero
   assign isFree = (stored.value == hw_mutex_pkg::VALUE_FREE);

   // Free lock or matching owner; owner match also lets the holder release
   assign allow = isFree || (written.owner == stored.owner);

endmodule : mutex_write_gate

// >>> verif/cpu_bus_model.sv
// Bus master model for the processors that share the lock
`timescale 1ns/100ps
module cpu_bus_model (
   input wire logic mclk,
   output hw_mutex_pkg::bus_req_t busReq,
   input wire logic [31:0] rdData
);
   // ---------------------------------------------
   // Zero-wait accesses launched off the falling edge
   // ---------------------------------------------
   initial begin
      busReq = '0;
   end
   // Released data shows the inverse so stale values cannot pass
   task automatic access(input logic wr, input logic addr, input logic [31:0] data, output logic [31:0] got);
      @(negedge mclk);
      busReq <= {1'h1, ~wr, wr, addr, data};
      @(negedge mclk);
      got = rdData;
      busReq <= {3'h0, addr, ~data};
   endtask : access
   // Own distinct identity with a non-zero value, then confirm ownership
   task automatic acquire(input logic [15:0] cpuId, input logic [15:0] val, output logic [31:0] got);
      logic [31:0] junk;
      access(1'h1, 1'h0, {cpuId, val}, junk);
      access(1'h0, 1'h0, 32'h0000_0000, got);
   endtask : acquire
   // Release keeps the identity and zeroes the value
   task automatic release_lock(input logic [15:0] cpuId);
      logic [31:0] junk;
      access(1'h1, 1'h0, {cpuId, 16'h0000}, junk);
   endtask : release_lock
endmodule : cpu_bus_model

// >>> verif/test_hw_mutex_core.sv
// Self-checking testbench for the hardware mutex core
`timescale 1ns/100ps
module test_hw_mutex_core;
   // ---------------------------------------------
   // Clock, reset and instances
   // ---------------------------------------------
   localparam int INIT_V = 32'h0000_0003;
   localparam int INIT_O = 32'h0000_00a1;
   localparam logic [15:0] CPU_A = 16'h00a1;
   localparam logic [15:0] CPU_B = 16'h00b2;
   logic mclk = 1'h0;
   logic rst_n = 1'h0;
   hw_mutex_pkg::bus_req_t busReq;
   logic [31:0] rdData;
   logic lockHeld;
   logic [31:0] word;
   int badCount = 0;
   int comparisons = 0;
   int cycles = 0;
   always #25 mclk = ~mclk;
   hw_mutex_core #(.INIT_VALUE(INIT_V), .INIT_OWNER(INIT_O)) dut (.mclk(mclk), .rst_n(rst_n),
      .busReq(busReq), .rdData(rdData), .lockHeld(lockHeld));
   cpu_bus_model cpu (.mclk(mclk), .busReq(busReq), .rdData(rdData));
   // ---------------------------------------------
   // Compare and verdict
   // ---------------------------------------------
   // Case inequality so an unknown never matches
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         badCount++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic giveVerdict;
      $display("comparisons %0d, mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : giveVerdict
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic test_reset_state;
      cpu.access(1'h0, 1'h0, 32'h0000_0000, word);
      check("lock word", {CPU_A, 16'h0003}, word);
      check("held", 32'h0000_0001, {31'h0, lockHeld});
      cpu.access(1'h0, 1'h1, 32'h0000_0000, word);
      check("boot flag", 32'h0000_0001, word);
      $display("test_reset_state done");
   endtask : test_reset_state
   // Foreign owner may not take a lock held from reset
   task automatic test_foreign_refused;
      cpu.access(1'h1, 1'h0, {CPU_B, 16'h0007}, word);
      cpu.access(1'h0, 1'h0, 32'h0000_0000, word);
      check("lock word", {CPU_A, 16'h0003}, word);
      cpu.access(1'h0, 1'h0, 32'h0000_0000, word);
      check("reread", {CPU_A, 16'h0003}, word);
      $display("test_foreign_refused done");
   endtask : test_foreign_refused
   task automatic test_owner_release;
      cpu.access(1'h1, 1'h0, {CPU_A, 16'h0009}, word);
      cpu.access(1'h0, 1'h0, 32'h0000_0000, word);
      check("owner update", {CPU_A, 16'h0009}, word);
      cpu.release_lock(CPU_A);
      check("held", 32'h0000_0000, {31'h0, lockHeld});
      cpu.access(1'h0, 1'h0, 32'h0000_0000, word);
      check("released", {CPU_A, 16'h0000}, word);
      $display("test_owner_release done");
   endtask : test_owner_release
   // Second processor wins, first is then shut out
   task automatic test_contend;
      cpu.acquire(CPU_B, 16'h0001, word);
      check("acquired", {CPU_B, 16'h0001}, word);
      check("held", 32'h0000_0001, {31'h0, lockHeld});
      cpu.acquire(CPU_A, 16'h0004, word);
      check("contended", {CPU_B, 16'h0001}, word);
      $display("test_contend done");
   endtask : test_contend
   task automatic test_boot_flag;
      cpu.access(1'h1, 1'h1, 32'hffff_fffe, word);
      cpu.access(1'h0, 1'h1, 32'h0000_0000, word);
      check("boot kept", 32'h0000_0001, word);
      cpu.access(1'h1, 1'h1, 32'h0000_0001, word);
      cpu.access(1'h0, 1'h1, 32'h0000_0000, word);
      check("boot clear", 32'h0000_0000, word);
      cpu.access(1'h1, 1'h1, 32'hffff_ffff, word);
      cpu.access(1'h0, 1'h1, 32'h0000_0000, word);
      check("boot upper", 32'h0000_0000, word);
      $display("test_boot_flag done");
   endtask : test_boot_flag
   // Reset in mid-run restores the build-time word and sets the flag again
   task automatic test_second_reset;
      rst_n = 1'h0;
      repeat (3) @(negedge mclk);
      rst_n = 1'h1;
      check("held", 32'h0000_0001, {31'h0, lockHeld});
      cpu.access(1'h0, 1'h0, 32'h0000_0000, word);
      check("lock word", {CPU_A, 16'h0003}, word);
      cpu.access(1'h0, 1'h1, 32'h0000_0000, word);
      check("boot flag", 32'h0000_0001, word);
      $display("test_second_reset done");
   endtask : test_second_reset
   // ---------------------------------------------
   // Main sequence and hang guard
   // ---------------------------------------------
   initial begin
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'h1;
      test_reset_state();
      test_foreign_refused();
      test_owner_release();
      test_contend();
      test_boot_flag();
      test_second_reset();
      giveVerdict();
   end
   // Whole run needs about 66 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         badCount++;
         giveVerdict();
      end
   end
endmodule : test_hw_mutex_core
